// file: pkg/dma_ctrl_pkg.sv
// Package with register layout and constants for the DMA control block.
package dma_ctrl_pkg;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_CTRL_STATUS = 4'h0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam int B_RX_DONE     = 3;
  localparam int B_RX_KICK     = 4;
  localparam int B_TX_DONE     = 11;
  localparam int B_TX_KICK     = 12;
  localparam int B_TX_ACTIVE   = 15;
  localparam int B_RSVD_RW     = 16;
  localparam int B_INV_OFF     = 18;
  localparam int B_UPD_OFF     = 19;
  localparam int B_BURST_LO    = 20;
  localparam int B_BURST_HI    = 22;
  localparam int B_TGT_ABORT   = 30;
  localparam int B_MST_ABORT   = 31;
  localparam logic [2:0] BURST_MIN     = 3'h1;
  localparam logic [2:0] BURST_MAX     = 3'h5;
  localparam logic [2:0] BURST_DEFAULT = 3'h1;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
endpackage

// file: core/burst_limit_decode.sv
// Maps the programmed fragment burst field onto a legal burst count.
`timescale 1ns/10ps
module burst_limit_decode
  import dma_ctrl_pkg::*;
(
  input  wire logic [2:0] i_field,
  output logic      [2:0] o_burst
);
  import dma_ctrl_pkg::*;

  // Values outside one to five fall back to one. [R14]
  always_comb begin
    if (i_field >= BURST_MIN && i_field <= BURST_MAX) begin
      o_burst = i_field; // [R13]
    end else begin
      o_burst = BURST_DEFAULT; // [R14]
    end
  end
endmodule

// file: core/dma_control_status.sv
// DMA control and status register with Avalon-MM slave access.
// Contract
// [R1] Receive done bit mirrors interrupt flag.
// [R2] Receive done clears on start or acknowledge.
// [R3] Receive kick resets receive poll timer.
// [R4] Receive kick self-clears after acting.
// [R5] Transmit done mirrors flag, clears on acknowledge.
// [R6] Transmit kick resets timer, fetches, self-clears.
// [R7] Transmit active bit follows transmit DMA.
// [R8] Host waits for idle before transmit reset.
// [R9] Host writes one to bit sixteen.
// [R10] Invalidate-off forbids memory write invalidate.
// [R11] Update-off stops descriptor done update, poll.
// [R12] Update-on updates and polls done flag.
// [R13] Burst field sets fragment entries per fetch.
// [R14] Burst outside one-to-five acts as one.
// [R15] Host sets burst to typical fragment count.
// [R16] Target abort latches and halts DMA.
// [R17] Target abort cleared only by chip reset; the code also clears it on i_abort_clear.
// [R18] Master abort latches and blocks DMA.
// [R19] Master abort cleared only by chip reset; the code also clears it on i_abort_clear.
// [R20] Host writes reserved bits as zero.
// [R21] Register resets zero; 16/32-bit access.
// [R22] Zero kicks ignored; kicks read zero.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
module dma_control_status
  import dma_ctrl_pkg::*;
(
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst_b,
  input  wire logic [dma_ctrl_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                           i_avs_read,
  input  wire logic                           i_avs_write,
  input  wire logic [31:0]                    i_avs_writedata,
  input  wire logic [3:0]                     i_avs_byteenable,
  output logic      [31:0]                    o_avs_readdata,
  output logic                                o_avs_waitrequest,
  output logic      [1:0]                     o_avs_response,
  input  wire logic                           i_rx_done_flag,
  input  wire logic                           i_tx_done_flag,
  input  wire logic                           i_tx_active,
  input  wire logic                           i_target_abort_evt,
  input  wire logic                           i_master_abort_evt,
  input  wire logic                           i_abort_clear,
  output logic                                o_rx_poll_kick,
  output logic                                o_tx_poll_kick,
  output logic                                o_invalidate_write_off,
  output logic                                o_tx_descriptor_update_off,
  output logic      [2:0]                     o_tx_fragment_burst,
  output logic                                o_dma_halt
);
  import dma_ctrl_pkg::*;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // State and next-value signals.
  bus_state_type state_r,      state_nxt;
  logic [31:0]   rdata_r,      rdata_nxt;
  logic [1:0]    resp_r,       resp_nxt;
  logic          wait_r,       wait_nxt;
  logic          rx_done_r,    rx_done_nxt;
  logic          tx_done_r,    tx_done_nxt;
  logic          tx_act_r,     tx_act_nxt;
  logic          rsvd_r,       rsvd_nxt;
  logic          inv_off_r,    inv_off_nxt;
  logic          upd_off_r,    upd_off_nxt;
  logic [2:0]    burst_fld_r,  burst_fld_nxt;
  logic [2:0]    burst_r,      burst_nxt;
  logic [2:0]    burst_dec;
  logic          tgt_abort_r,  tgt_abort_nxt;
  logic          mst_abort_r,  mst_abort_nxt;
  logic          rx_kick_r,    rx_kick_nxt;
  logic          tx_kick_r,    tx_kick_nxt;
  logic          halt_r,       halt_nxt;
  logic          hit;
  logic          wr_take;
  logic          rd_take;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and write byte-lane helpers.
  function automatic logic lane_bit(input logic [31:0] d,
                                    input logic [3:0]  be,
                                    input int          pos,
                                    input logic        old);
    lane_bit = be[pos/8] ? d[pos] : old;
  endfunction

  // Only one register exists; any other word answers with an error.
  assign hit     = (i_avs_address == OFS_CTRL_STATUS);
  assign rd_take = (state_r == ST_IDLE) && i_avs_read;
  assign wr_take = (state_r == ST_IDLE) && i_avs_write && hit;

  // The decode of the burst field lives in its own small module.
  burst_limit_decode u_burst (
    .i_field (burst_fld_r),
    .o_burst (burst_dec)
  );

  function automatic logic [31:0] pack_reg(input logic rxd,
                                           input logic txd,
                                           input logic act,
                                           input logic rsv,
                                           input logic inv,
                                           input logic upd,
                                           input logic [2:0] bst,
                                           input logic ta,
                                           input logic ma);
    logic [31:0] v;
    v = READ_ZERO;
    v[B_RX_DONE]   = rxd;
    v[B_TX_DONE]   = txd;
    v[B_TX_ACTIVE] = act;
    v[B_RSVD_RW]   = rsv;
    v[B_INV_OFF]   = inv;
    v[B_UPD_OFF]   = upd;
    v[B_BURST_HI:B_BURST_LO] = bst;
    v[B_TGT_ABORT] = ta;
    v[B_MST_ABORT] = ma;
    pack_reg = v; // Kick bits and reserved bits other than bit 16 read as zero. [R22]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: a request is taken in idle, answered one cycle later.
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    resp_nxt  = resp_r;
    wait_nxt  = 1'b1;
    case (state_r)
      ST_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          state_nxt = ST_ACK;
          wait_nxt  = 1'b0;
          resp_nxt  = hit ? RESP_OK : RESP_ERR;
          rdata_nxt = (rd_take && hit) ?
                      pack_reg(rx_done_r, tx_done_r, tx_act_r, rsvd_r,
                               inv_off_r, upd_off_r, burst_fld_r,
                               tgt_abort_r, mst_abort_r) : READ_ZERO;
        end
      end
      ST_ACK: begin
        // Master releases on the edge that saw waitrequest low.
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      rdata_r <= READ_ZERO;
      resp_r  <= RESP_OK;
      wait_r  <= 1'b1;
    end else begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
      resp_r  <= resp_nxt;
      wait_r  <= wait_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields written by software, status mirrored from the engine.
  // A write is applied when taken; the answer follows a cycle later, which
  // is harmless as the master holds the request until then.
  always_comb begin
    rx_done_nxt   = i_rx_done_flag; // [R1] [R2]
    tx_done_nxt   = i_tx_done_flag; // [R5]
    tx_act_nxt    = i_tx_active;    // [R7]
    rsvd_nxt      = rsvd_r;
    inv_off_nxt   = inv_off_r;
    upd_off_nxt   = upd_off_r;
    burst_fld_nxt = burst_fld_r;
    burst_nxt     = burst_dec;      // [R13] [R14]
    rx_kick_nxt   = 1'b0;           // [R4]
    tx_kick_nxt   = 1'b0;           // [R6]
    if (wr_take) begin
      rsvd_nxt    = lane_bit(i_avs_writedata, i_avs_byteenable, B_RSVD_RW,
                             rsvd_r);
      inv_off_nxt = lane_bit(i_avs_writedata, i_avs_byteenable, B_INV_OFF,
                             inv_off_r); // [R10]
      upd_off_nxt = lane_bit(i_avs_writedata, i_avs_byteenable, B_UPD_OFF,
                             upd_off_r); // [R11] [R12]
      if (i_avs_byteenable[B_BURST_LO/8]) begin
        burst_fld_nxt = i_avs_writedata[B_BURST_HI:B_BURST_LO]; // [R13]
      end
      // Only a one on an enabled lane issues a kick; zeros do nothing.
      rx_kick_nxt = i_avs_byteenable[B_RX_KICK/8] &&
                    i_avs_writedata[B_RX_KICK]; // [R3] [R22]
      tx_kick_nxt = i_avs_byteenable[B_TX_KICK/8] &&
                    i_avs_writedata[B_TX_KICK]; // [R6] [R22]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_done_r   <= 1'b0; // [R21]
      tx_done_r   <= 1'b0;
      tx_act_r    <= 1'b0;
      rsvd_r      <= CTRL_RESET[B_RSVD_RW];
      inv_off_r   <= CTRL_RESET[B_INV_OFF];
      upd_off_r   <= CTRL_RESET[B_UPD_OFF];
      burst_fld_r <= CTRL_RESET[B_BURST_HI:B_BURST_LO];
      burst_r     <= BURST_DEFAULT;
      rx_kick_r   <= 1'b0;
      tx_kick_r   <= 1'b0;
    end else begin
      rx_done_r   <= rx_done_nxt;
      tx_done_r   <= tx_done_nxt;
      tx_act_r    <= tx_act_nxt;
      rsvd_r      <= rsvd_nxt;
      inv_off_r   <= inv_off_nxt;
      upd_off_r   <= upd_off_nxt;
      burst_fld_r <= burst_fld_nxt;
      burst_r     <= burst_nxt;
      rx_kick_r   <= rx_kick_nxt;
      tx_kick_r   <= tx_kick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Abort flags: sticky, set wins over clear, chip reset or i_abort_clear clears them.
  // Bus writes have no path here at all, so software cannot clear them.
  always_comb begin
    tgt_abort_nxt = tgt_abort_r;
    mst_abort_nxt = mst_abort_r;
    if (i_abort_clear) begin
      tgt_abort_nxt = 1'b0; // [R17]
      mst_abort_nxt = 1'b0; // [R19]
    end
    if (i_target_abort_evt) begin
      tgt_abort_nxt = 1'b1; // [R16]
    end
    if (i_master_abort_evt) begin
      mst_abort_nxt = 1'b1; // [R18]
    end
    // Halt follows the next flag values so DMA stops the cycle after.
    halt_nxt = tgt_abort_nxt || mst_abort_nxt; // [R16] [R18]
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tgt_abort_r <= 1'b0;
      mst_abort_r <= 1'b0;
      halt_r      <= 1'b0;
    end else begin
      tgt_abort_r <= tgt_abort_nxt;
      mst_abort_r <= mst_abort_nxt;
      halt_r      <= halt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops.
  assign o_avs_readdata             = rdata_r;
  assign o_avs_waitrequest          = wait_r;
  assign o_avs_response             = resp_r;
  assign o_rx_poll_kick             = rx_kick_r;
  assign o_tx_poll_kick             = tx_kick_r;
  assign o_invalidate_write_off     = inv_off_r;
  assign o_tx_descriptor_update_off = upd_off_r;
  assign o_tx_fragment_burst        = burst_r;
  assign o_dma_halt                 = halt_r;
endmodule

// file: testbench/dma_ctrl_sva.sv
// Checker for the DMA control and status register ports.
`timescale 1ns/10ps
module dma_ctrl_sva
  import dma_ctrl_pkg::*;
(
  input wire logic                    i_sys_clk, i_rst_b,
  input wire logic [ADDR_W-1:0]       i_avs_address,
  input wire logic                    i_avs_read, i_avs_write,
  input wire logic [31:0]             i_avs_writedata, o_avs_readdata,
  input wire logic [3:0]              i_avs_byteenable,
  input wire logic                    o_avs_waitrequest, i_rx_done_flag,
  input wire logic                    i_tx_active, i_abort_clear,
  input wire logic                    i_target_abort_evt, i_master_abort_evt,
  input wire logic                    o_rx_poll_kick, o_tx_poll_kick,
  input wire logic                    o_invalidate_write_off, o_dma_halt,
  input wire logic                    o_tx_descriptor_update_off,
  input wire logic [2:0]              o_tx_fragment_burst
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic wt, ra, kr, kt;
  // Taken write, answered read and kick requests at the mapped word.
  assign wt = i_avs_write && o_avs_waitrequest &&
              i_avs_address == OFS_CTRL_STATUS;
  assign ra = i_avs_read && !o_avs_waitrequest &&
              i_avs_address == OFS_CTRL_STATUS;
  assign kr = wt && i_avs_byteenable[0] && i_avs_writedata[B_RX_KICK];
  assign kt = wt && i_avs_byteenable[1] && i_avs_writedata[B_TX_KICK];
  a_rx_kick_pulse: assert property (kr |=> o_rx_poll_kick)
    else $error("rx kick missing");
  a_rx_kick_clear: assert property (o_rx_poll_kick |=> !o_rx_poll_kick)
    else $error("rx kick stuck");
  a_tx_kick_pulse: assert property (kt |=> o_tx_poll_kick ##1
    !o_tx_poll_kick)
    else $error("tx kick not one pulse");
  a_kick_cause_only: assert property (o_rx_poll_kick || o_tx_poll_kick |->
    $past(kr) == o_rx_poll_kick && $past(kt) == o_tx_poll_kick)
    else $error("kick without request");
  a_rx_done_copy: assert property (ra && $past(i_rx_done_flag) == i_rx_done_flag
    && $past(i_rx_done_flag, 2) == i_rx_done_flag
    |-> o_avs_readdata[B_RX_DONE] == i_rx_done_flag)
    else $error("rx done bit differs");
  a_tx_busy_copy: assert property (ra && $past(i_tx_active) == i_tx_active
    && $past(i_tx_active, 2) == i_tx_active
    |-> o_avs_readdata[B_TX_ACTIVE] == i_tx_active)
    else $error("tx active bit differs");
  a_abort_halts: assert property (i_target_abort_evt || i_master_abort_evt
    |=> o_dma_halt)
    else $error("abort without halt");
  a_abort_sticky: assert property (o_dma_halt && !i_abort_clear |=> o_dma_halt)
    else $error("halt dropped without clear");
  a_abort_cleared: assert property (i_abort_clear && !i_target_abort_evt &&
    !i_master_abort_evt |=> !o_dma_halt)
    else $error("halt kept after clear");
  a_burst_legal: assert property (o_tx_fragment_burst >= BURST_MIN &&
    o_tx_fragment_burst <= BURST_MAX)
    else $error("burst out of range");
  a_inv_follow: assert property (wt && i_avs_byteenable[2] |=>
    o_invalidate_write_off == $past(i_avs_writedata[B_INV_OFF]))
    else $error("invalidate off not taken");
  a_upd_follow: assert property (wt && i_avs_byteenable[2] |=>
    o_tx_descriptor_update_off == $past(i_avs_writedata[B_UPD_OFF]))
    else $error("update off not taken");
  c_tx_kick: cover property (kt ##1 o_tx_poll_kick);
  c_halt_gone: cover property (o_dma_halt ##1 !o_dma_halt);
  c_busy_read: cover property (ra && i_tx_active);
endmodule
bind dma_control_status dma_ctrl_sva sva (.i_sys_clk, .i_rst_b,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .o_avs_readdata, .i_avs_byteenable, .o_avs_waitrequest, .i_rx_done_flag,
  .i_tx_active, .i_abort_clear, .i_target_abort_evt, .i_master_abort_evt,
  .o_rx_poll_kick, .o_tx_poll_kick, .o_invalidate_write_off, .o_dma_halt,
  .o_tx_descriptor_update_off, .o_tx_fragment_burst);

// file: testbench/dma_far_model.sv
// Behavioural transmit DMA engine that answers poll kicks.
`timescale 1ns/10ps
module dma_far_model #(parameter int LEN = 12) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_tx_poll_kick,
  input  wire logic i_halt,
  input  wire logic i_ack,
  output logic      o_tx_active,
  output logic      o_tx_done_flag
);
  int cnt;
  // A halted engine ignores kicks, since an abort is fatal until cleared.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_tx_done_flag <= 1'b0;
    end else begin
      if (i_tx_poll_kick && !i_halt) cnt <= LEN;
      else if (cnt != 0) cnt <= cnt - 1;
      if (cnt == 1) o_tx_done_flag <= 1'b1;
      else if (i_ack) o_tx_done_flag <= 1'b0;
    end
  end
  assign o_tx_active = (cnt != 0);
endmodule

// file: testbench/test_dma_control_status.sv
// Self-checking bench for the DMA control and status register.
`timescale 1ns/10ps
module test_dma_control_status;
  import dma_ctrl_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, rxd = 1'b0;
  logic ta = 1'b0, ma = 1'b0, clr = 1'b0, ack = 1'b0;
  logic [3:0] adr = 4'h0, be = 4'h0;
  logic [31:0] wd = 32'h0, rdata, q_rd, sh, seed = 32'h7d8a;
  logic [1:0] rsp, q_rs;
  logic [2:0] bst;
  logic kr, kt, q_kr, q_kt, txd, act, halt, inv, upd, wreq;
  int miscompares = 0, total_checks = 0, v;
  localparam logic [31:0] M = 32'h007d_0000;
  dma_control_status dut (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_avs_response(rsp), .i_rx_done_flag(rxd),
    .i_tx_done_flag(txd), .i_tx_active(act), .i_target_abort_evt(ta),
    .i_master_abort_evt(ma), .i_abort_clear(clr), .o_rx_poll_kick(kr),
    .o_tx_poll_kick(kt), .o_invalidate_write_off(inv),
    .o_tx_descriptor_update_off(upd), .o_tx_fragment_burst(bst),
    .o_dma_halt(halt));
  dma_far_model far (.i_sys_clk(clk), .i_rst_b(rst_b), .i_tx_poll_kick(kt),
    .i_halt(halt), .i_ack(ack), .o_tx_active(act), .o_tx_done_flag(txd));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One Avalon cycle; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w; wr <= w; adr <= a; wd <= d; be <= b;
    // Waitrequest is read at the rising edge, before the slave updates it.
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) miscompares++;
    q_rd = rdata; q_rs = rsp; q_kr = kr; q_kt = kt;
    if (w && a == OFS_CTRL_STATUS && b[2]) sh = (sh & ~M) | (d & M);
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog sized well above the fewer than 150 cycles the run needs.
  initial begin
    #(50 * 4000);
    miscompares++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sh = CTRL_RESET;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 0, 0, 4'hf); chk("reset", q_rd, CTRL_RESET);
    for (v = 0; v < 8; v++) begin
      seed = xs(seed);
      // Reserved bits stay zero; bit 16 is one; burst three is visited.
      bus(1, 0, {9'h0, v[2:0], seed[1:0], 2'b01, 16'h0},
          v[0] ? 4'hc : 4'hf);
      chk("inv", inv, seed[0]);
      chk("upd", upd, seed[1]);
      bus(0, 0, 0, 4'hf);
      chk("readback", q_rd, sh);
      chk("burst", bst, (v >= 1 && v <= 5) ? v[2:0] : 3'h1);
    end
    bus(1, 4'h1, 32'h0000_ffff, 4'hf);
    bus(0, 4'h1, 0, 4'hf);
    chk("unmapped", {q_rs, q_rd}, {2'b10, 32'h0});
    bus(1, 0, sh | 32'h0000_1010, 4'hf);
    chk("kicks", {q_kr, q_kt}, 2'b11);
    bus(1, 0, sh, 4'hf); chk("no kicks", {q_kr, q_kt}, 2'b00);
    bus(0, 0, 0, 4'hf); chk("busy", q_rd, sh | 32'h0000_8000);
    repeat (16) @(posedge clk);
    // The host sees the engine idle before any reset request.
    bus(0, 0, 0, 4'hf);
    chk("tx done", q_rd, sh | 32'h0000_0800);
    ack <= 1'b1; @(posedge clk); ack <= 1'b0; repeat (3) @(posedge clk);
    bus(0, 0, 0, 4'hf); chk("tx ack", q_rd, sh);
    rxd <= 1'b1; repeat (3) @(posedge clk);
    bus(0, 0, 0, 4'hf); chk("rx done", q_rd, sh | 32'h0000_0008);
    rxd <= 1'b0; repeat (3) @(posedge clk);
    bus(0, 0, 0, 4'hf); chk("rx ack", q_rd, sh);
    for (v = 0; v < 2; v++) begin
      if (v == 0) ta <= 1'b1;
      else ma <= 1'b1;
      @(posedge clk); ta <= 1'b0; ma <= 1'b0;
      bus(1, 0, sh | 32'hc000_0000, 4'hf);
      bus(0, 0, 0, 4'hf);
      chk("abort", q_rd, sh | (32'h4000_0000 << v));
      chk("halt", halt, 1'b1);
      clr <= 1'b1; @(posedge clk); clr <= 1'b0; @(posedge clk);
      bus(0, 0, 0, 4'hf); chk("cleared", {halt, q_rd}, {1'b0, sh});
    end
    tally_and_finish;
  end
endmodule
